// >>> leading_bit_counter.sv
`timescale 1ns/1ps
// Function
// - Leading ones are counted from bit 31 down until the first clear bit.
// - An all-ones operand gives a leading-ones count of 32.
// - Leading zeros are counted from bit 31 down until the first set bit.
// - An all-zero operand gives a leading-zeros count of 32.
// - Older encoding: opcode 011100 with function 100001 is ones, 100000 is zeros.
// - Newer encoding: opcode 000000 with function 010001 is ones, 010000 is zeros.
// - Newer encoding needs bits 20..16 equal 00000 and bits 10..6 equal 00001.
module leading_bit_counter
  import lbc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Issue from decode
  input wire logic issue_valid,
  input wire logic [lbc_pkg::WORD_W-1:0] instr,
  input wire logic [lbc_pkg::WORD_W-1:0] general_register_src,
  // Decode outcome
  output logic accepted,
  // Write-back
  output logic result_valid_reg,
  output logic [lbc_pkg::REG_W-1:0] result_dest_reg,
  output logic [lbc_pkg::WORD_W-1:0] result_data_reg
);
  import lbc_pkg::*;

  logic [lbc_pkg::CNT_W-1:0] lead_zero_count;
  logic [lbc_pkg::WORD_W-1:0] scan_word;
  logic [5:0] opcode;
  logic [5:0] func;
  logic [4:0] second_reg_field;
  logic [4:0] shamt_field;
  logic [4:0] dest_field;
  logic old_form;
  logic new_form;
  logic count_leading_ones_op;
  logic count_leading_zeros_op;

  assign opcode = instr[OPC_HI:OPC_LO];
  assign func = instr[FN_HI:FN_LO];
  assign second_reg_field = instr[SECOND_HI:SECOND_LO];
  assign shamt_field = instr[SA_HI:SA_LO];
  assign dest_field = instr[RD_HI:RD_LO];

  // Older form ignores a mismatched second-source field; the issuer keeps it equal.
  assign old_form = (opcode == OPC_SECONDARY_GROUP) && (shamt_field == OLD_SHAMT_FIELD);
  assign new_form = (opcode == OPC_PRIMARY_ZERO) && (second_reg_field == NEW_SECOND_FIELD)
    && (shamt_field == NEW_SHAMT_FIELD);
  assign count_leading_ones_op = (old_form && func == FN_OLD_ONES)
    || (new_form && func == FN_NEW_ONES);
  assign count_leading_zeros_op = (old_form && func == FN_OLD_ZEROS)
    || (new_form && func == FN_NEW_ZEROS);
  assign accepted = issue_valid && (count_leading_ones_op || count_leading_zeros_op);

  // One shared counter: leading ones of x are leading zeros of ~x.
  assign scan_word = count_leading_ones_op ? ~general_register_src : general_register_src;

  lead_count u_count (
    .word(scan_word),
    .count(lead_zero_count)
  );

  // Results hold until the next accepted count, so a stalled write-back can read them again.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_valid_reg <= 1'b0;
      result_dest_reg <= DEST_RESET;
      result_data_reg <= RESULT_RESET;
    end
    else
    begin
      result_valid_reg <= accepted;
      if (accepted)
      begin
        result_dest_reg <= dest_field;
        result_data_reg <= {{(WORD_W-CNT_W){1'b0}}, lead_zero_count};
      end
    end
  end

  // Reference count for checking, written independently of the shared counter.
  function automatic logic [CNT_W-1:0] ref_count(input logic [WORD_W-1:0] w, input logic ones);
    logic [CNT_W-1:0] c;
    logic done;
    c = FULL_COUNT;
    done = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      if (!done && (w[i] != ones))
      begin
        c = CNT_W'(WORD_W - 1 - i);
        done = 1'b1;
      end
    end
    return c;
  endfunction

  property p_ones_count;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_ones_op) |=> result_data_reg ==
      {{(WORD_W-CNT_W){1'b0}}, ref_count($past(general_register_src), 1'b1)};
  endproperty
  a_ones_count: assert property (p_ones_count) else $error("leading ones count wrong");

  property p_ones_full;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_ones_op && &general_register_src) |=> result_data_reg == 32'h20;
  endproperty
  a_ones_full: assert property (p_ones_full) else $error("all ones not 32");

  property p_zeros_count;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_zeros_op) |=> result_data_reg ==
      {{(WORD_W-CNT_W){1'b0}}, ref_count($past(general_register_src), 1'b0)};
  endproperty
  a_zeros_count: assert property (p_zeros_count) else $error("leading zeros count wrong");

  property p_zeros_full;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_zeros_op && general_register_src == 32'h0) |=>
      result_data_reg == 32'h20;
  endproperty
  a_zeros_full: assert property (p_zeros_full) else $error("all zeros not 32");

  property p_old_decode;
    @(posedge clk) disable iff (rst)
    (issue_valid && opcode == 6'h1c && shamt_field == 5'h00 && (func == 6'h21 || func == 6'h20))
      |-> accepted ##1 result_valid_reg;
  endproperty
  a_old_decode: assert property (p_old_decode) else $error("older form not taken");

  property p_new_decode;
    @(posedge clk) disable iff (rst)
    (issue_valid && opcode == 6'h00 && second_reg_field == 5'h00 && shamt_field == 5'h01
      && (func == 6'h11 || func == 6'h10)) |-> accepted ##1 result_valid_reg;
  endproperty
  a_new_decode: assert property (p_new_decode) else $error("newer form not taken");

  property p_new_fields;
    @(posedge clk) disable iff (rst)
    (issue_valid && opcode == 6'h00 && (second_reg_field != 5'h00 || shamt_field != 5'h01))
      |-> !accepted ##1 !result_valid_reg;
  endproperty
  a_new_fields: assert property (p_new_fields) else $error("bad fixed fields taken");

  property p_range;
    @(posedge clk) disable iff (rst)
    result_valid_reg |-> (result_data_reg <= 32'h20) && $past(accepted);
  endproperty
  a_range: assert property (p_range) else $error("result out of range");

  property p_dest;
    @(posedge clk) disable iff (rst)
    accepted |=> result_dest_reg == $past(dest_field);
  endproperty
  a_dest: assert property (p_dest) else $error("destination field lost");

  property p_idle_refused;
    @(posedge clk) disable iff (rst)
    !issue_valid |-> !accepted;
  endproperty
  a_idle_refused: assert property (p_idle_refused) else $error("taken without issue");

  property p_valid_set;
    @(posedge clk) disable iff (rst)
    accepted |=> result_valid_reg;
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("result pulse missing");

  property p_valid_clear;
    @(posedge clk) disable iff (rst)
    !accepted |=> !result_valid_reg;
  endproperty
  a_valid_clear: assert property (p_valid_clear) else $error("pulse without issue");

  // A refused word must not disturb the last result, since no exception reports it.
  property p_hold_data;
    @(posedge clk) disable iff (rst)
    !accepted |=> $stable(result_data_reg);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("result changed on refusal");

  property p_hold_dest;
    @(posedge clk) disable iff (rst)
    !accepted |=> $stable(result_dest_reg);
  endproperty
  a_hold_dest: assert property (p_hold_dest) else $error("destination changed");

  property p_ones_none;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_ones_op && !general_register_src[31])
      |=> result_data_reg == 32'h0;
  endproperty
  a_ones_none: assert property (p_ones_none) else $error("clear top bit not 0");

  property p_ones_one;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_ones_op && general_register_src[31:30] == 2'b10)
      |=> result_data_reg == 32'h1;
  endproperty
  a_ones_one: assert property (p_ones_one) else $error("single leading one not 1");

  property p_zeros_none;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_zeros_op && general_register_src[31])
      |=> result_data_reg == 32'h0;
  endproperty
  a_zeros_none: assert property (p_zeros_none) else $error("set top bit not 0");

  property p_zeros_one;
    @(posedge clk) disable iff (rst)
    (accepted && count_leading_zeros_op && general_register_src[31:30] == 2'b01)
      |=> result_data_reg == 32'h1;
  endproperty
  a_zeros_one: assert property (p_zeros_one) else $error("single leading zero not 1");

  // No disable here: the cleared state after reset is itself what is checked.
  property p_reset_clear;
    @(posedge clk)
    rst |=> !result_valid_reg && result_data_reg == 32'h0 && result_dest_reg == 5'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

  c_ones: cover property (@(posedge clk) disable iff (rst) accepted && count_leading_ones_op);
  c_zeros: cover property (@(posedge clk) disable iff (rst) accepted && count_leading_zeros_op);
  c_full: cover property (@(posedge clk) disable iff (rst) result_data_reg == 32'h20);
  c_b2b: cover property (@(posedge clk) disable iff (rst) accepted ##1 accepted);
  c_refused: cover property (@(posedge clk) disable iff (rst) issue_valid && !accepted);
endmodule

// >>> lbc_pkg.sv
package lbc_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned REG_W = 5;
  localparam logic [5:0] OPC_SECONDARY_GROUP = 6'h1c;
  localparam logic [5:0] OPC_PRIMARY_ZERO = 6'h00;
  localparam logic [5:0] FN_OLD_ONES = 6'h21;
  localparam logic [5:0] FN_OLD_ZEROS = 6'h20;
  localparam logic [5:0] FN_NEW_ONES = 6'h11;
  localparam logic [5:0] FN_NEW_ZEROS = 6'h10;
  localparam logic [4:0] NEW_SECOND_FIELD = 5'h00;
  localparam logic [4:0] NEW_SHAMT_FIELD = 5'h01;
  localparam logic [4:0] OLD_SHAMT_FIELD = 5'h00;
  localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned SRC_HI = 25;
  localparam int unsigned SRC_LO = 21;
  localparam int unsigned SECOND_HI = 20;
  localparam int unsigned SECOND_LO = 16;
  localparam int unsigned RD_HI = 15;
  localparam int unsigned RD_LO = 11;
  localparam int unsigned SA_HI = 10;
  localparam int unsigned SA_LO = 6;
  localparam int unsigned FN_HI = 5;
  localparam int unsigned FN_LO = 0;
  localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [REG_W-1:0] DEST_RESET = 5'h00;
endpackage

// >>> lead_count.sv
`timescale 1ns/1ps
// Combinational leading-zero counter; ones are counted by inverting first.
module lead_count
  import lbc_pkg::*;
(
  // Operand and count
  input wire logic [lbc_pkg::WORD_W-1:0] word,
  output logic [lbc_pkg::CNT_W-1:0] count
);
  import lbc_pkg::*;

  logic [lbc_pkg::WORD_W:0] found;
  logic [lbc_pkg::CNT_W-1:0] partial [0:lbc_pkg::WORD_W];

  assign found[0] = 1'b0;
  assign partial[0] = FULL_COUNT;

  // Scan from bit 31 down; the first set bit freezes the count at 31 - i.
  genvar g;
  generate
    for (g = 0; g < WORD_W; g = g + 1)
    begin : g_scan
      localparam int unsigned BIT = WORD_W - 1 - g;
      assign found[g+1] = found[g] | word[BIT];
      assign partial[g+1] = (!found[g] && word[BIT]) ? CNT_W'(g) : partial[g];
    end
  endgenerate

  assign count = partial[WORD_W];
endmodule

// >>> regfile_model.sv
`timescale 1ns/1ps
// Register file read port as the decode stage presents it to the counter.
module regfile_model
(
  // Instruction and operand
  input wire logic [31:0] instr,
  output logic [31:0] src
);
  logic [31:0] mem [32];
  initial
  begin
    for (int i = 0; i < 32; i++) mem[i] = 32'h0;
  end
  assign src = mem[instr[25:21]];
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lbc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  logic [WORD_W-1:0] instr = 32'h0;
  logic [WORD_W-1:0] src;
  logic accepted;
  logic result_valid_reg;
  logic [REG_W-1:0] result_dest_reg;
  logic [WORD_W-1:0] result_data_reg;
  int error_cnt = 0;
  int checked = 0;
  always #2 clk = ~clk;
  leading_bit_counter i_dut(.clk(clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
    .general_register_src(src), .accepted(accepted), .result_valid_reg(result_valid_reg),
    .result_dest_reg(result_dest_reg), .result_data_reg(result_data_reg));
  regfile_model i_rf(.instr(instr), .src(src));
  task automatic fail(string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  // Source field is the inverse of the destination so the register file read is exercised.
  function automatic logic [31:0] enc(logic nw, logic ones, logic [4:0] rd);
    if (nw)
      return {OPC_PRIMARY_ZERO, ~rd, NEW_SECOND_FIELD, rd, NEW_SHAMT_FIELD,
        ones ? FN_NEW_ONES : FN_NEW_ZEROS};
    return {OPC_SECONDARY_GROUP, ~rd, rd, rd, OLD_SHAMT_FIELD,
      ones ? FN_OLD_ONES : FN_OLD_ZEROS};
  endfunction
  // One idle cycle follows each issue so a held valid is never taken twice.
  task automatic issue(logic [31:0] i, logic [31:0] s, logic acc, logic [5:0] exp);
    logic [31:0] old;
    logic [4:0] old_dest;
    old = result_data_reg;
    old_dest = result_dest_reg;
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= i;
    i_rf.mem[i[SRC_HI:SRC_LO]] <= s;
    #1;
    checked++;
    if (result_valid_reg !== 1'b0) fail("pulse long");
    if (accepted !== acc) fail("decode");
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    checked++;
    if (accepted !== 1'b0) fail("idle taken");
    if (result_valid_reg !== acc) fail("pulse");
    if (acc && result_dest_reg !== i[RD_HI:RD_LO]) fail("dest");
    if (acc && result_data_reg !== {26'h0, exp}) fail("count");
    if (!acc && result_data_reg !== old) fail("held");
    if (!acc && result_dest_reg !== old_dest) fail("dest held");
  endtask
  // Two counts on consecutive edges; the result pulse stays high for both cycles, then drops.
  task automatic t_burst();
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= enc(1'b0, 1'b1, 5'h0a);
    i_rf.mem[5'h15] <= 32'hf000_0000;
    #1;
    checked++;
    if (accepted !== 1'b1) fail("burst decode a");
    @(posedge clk);
    instr <= enc(1'b1, 1'b0, 5'h0b);
    i_rf.mem[5'h14] <= 32'h0001_0000;
    #1;
    checked++;
    if (result_valid_reg !== 1'b1 || result_data_reg !== 32'h4) fail("burst count a");
    if (result_dest_reg !== 5'h0a || accepted !== 1'b1) fail("burst dest a");
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    checked++;
    if (result_valid_reg !== 1'b1 || result_data_reg !== 32'hf) fail("burst count b");
    if (result_dest_reg !== 5'h0b) fail("burst dest b");
    @(posedge clk);
    #1;
    checked++;
    if (result_valid_reg !== 1'b0 || result_data_reg !== 32'hf) fail("burst end");
  endtask
  task automatic t_ones();
    logic [31:0] v;
    for (int k = 0; k <= 32; k++)
    begin
      v = ~(32'hffffffff >> k);
      if (k < 31) v = v | 32'h1;
      issue(enc(k[0], 1'b1, k[4:0]), v, 1'b1, k[5:0]);
    end
  endtask
  task automatic t_zeros();
    for (int k = 0; k <= 32; k++)
    begin
      issue(enc(~k[0], 1'b0, k[4:0]), 32'hffffffff >> k, 1'b1, k[5:0]);
    end
  endtask
  task automatic t_refuse();
    logic [31:0] b [5];
    b[0] = enc(1'b1, 1'b1, 5'h04) ^ 32'h0001_0000;
    b[1] = enc(1'b1, 1'b0, 5'h04) ^ 32'h0000_0040;
    b[2] = enc(1'b0, 1'b1, 5'h04) ^ 32'h0000_0040;
    b[3] = enc(1'b0, 1'b0, 5'h04) ^ 32'h0000_0002;
    b[4] = enc(1'b1, 1'b1, 5'h04) ^ 32'h0400_0000;
    for (int j = 0; j < 5; j++) issue(b[j], 32'h0, 1'b0, 6'h00);
  endtask
  // A reset in mid-run clears earlier results and ignores an issue that it overlaps.
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    issue_valid <= 1'b1;
    instr <= enc(1'b1, 1'b1, 5'h1f);
    @(posedge clk);
    rst <= 1'b0;
    issue_valid <= 1'b0;
    #1;
    checked++;
    if (result_valid_reg !== 1'b0 || result_data_reg !== RESULT_RESET) fail("reset");
    if (result_dest_reg !== DEST_RESET) fail("reset dest");
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_ones();
    t_burst();
    t_reset();
    t_zeros();
    t_refuse();
    summarize();
  end
  initial
  begin
    #20000;
    fail("watchdog");
    summarize();
  end
endmodule
